// ---- hw/e1_loop_map.svh ----
// register map, field positions, reset values and timing counts
// Behaviour
// R1: line reset rising edge resets recovery and attenuator
// R2: host clears then sets bit again
// R3: host writes zero to unassigned bits
// R4: five-bit selector picks monitored receive timeslot
// R5: framer loop routes transmit into receive
// R6: framer loop transmits normally, ignores receive pins
// R7: framer loop replaces receive clock with transmit
// R8: local loop substitutes transmitted data for line
// R9: local loop data passes jitter attenuator
// R10: remote loop sends receive data back out
// R11: remote loop keeps framer, discards formatter output
// R12: host writes all registers after power-up
// R13: pulse line reset, wait 40 ms recovery
// R14: host toggles elastic reset zero-one-zero
// R15: system supplies transmit and receive clocks
// R16: auto alarm enables watch receive faults
// R17: any fault sends AIS or remote alarm
// R18: host never sets both alarm enables
// R19: no multiframe sync in 400 ms, constant alarm
// R20: elastic reset level forces stores, not left set
// R21: one reset pulse per detected rising edge
`ifndef E1_LOOP_MAP_SVH
`define E1_LOOP_MAP_SVH

`define E1_ADDR_CTRL_ONE 8'h10
`define E1_ADDR_CTRL_TWO 8'h11
`define E1_ADDR_CTRL_THREE 8'h1b
`define E1_ADDR_CTRL_FOUR 8'ha8
`define E1_ADDR_CTRL_FIVE 8'haa
`define E1_ADDR_MON_DATA 8'hac
`define E1_ADDR_STATUS 8'had

`define E1_RESET_VALUE 8'h00

`define E1_BIT_FRAMER_LOOP 7
`define E1_BIT_AIS_AUTO 5
`define E1_BIT_RAI_AUTO 4
`define E1_BIT_ELASTIC_RESET 4
`define E1_BIT_REMOTE_LOOP 7
`define E1_BIT_LOCAL_LOOP 6
`define E1_BIT_LINE_RESET 7
`define E1_SEL_MSB 4
`define E1_SEL_LSB 0

`define E1_STAT_RECOVERING 0
`define E1_STAT_FAULT 1
`define E1_STAT_CONST_RAI 2
`define E1_STAT_SEND_AIS 3
`define E1_STAT_SEND_RAI 4

`define E1_CORE_CLK_HZ 20000000
`define E1_RECOVERY_MS 40
`define E1_MF_SEARCH_MS 400
`define E1_RECOVERY_CYCLES (`E1_RECOVERY_MS * (`E1_CORE_CLK_HZ / 1000))
`define E1_MF_SEARCH_CYCLES (`E1_MF_SEARCH_MS * (`E1_CORE_CLK_HZ / 1000))

`endif

// ---- hw/e1_loop_pkg.sv ----
// types shared by the loopback and alarm control block
package e1_loop_pkg;

	// one bipolar line symbol
	typedef struct packed {
		logic pos;
		logic neg;
	} bipolar_t;

	// controls handed from the register side to the line side
	typedef struct packed {
		logic framer_loop_mode;
		logic local_loop_mode;
		logic remote_loop_mode;
		logic send_ais;
		logic send_rai;
	} link_ctrl_t;

	// receive fault inputs
	typedef struct packed {
		logic frame_sync_lost;
		logic ais_received;
		logic carrier_lost;
		logic crc4_mf_found;
	} rx_fault_t;

endpackage

// ---- hw/e1_loopback_alarm_control.sv ----
// loopback, line reset, channel monitor and automatic alarm control
`timescale 1ns/10ps
`include "e1_loop_map.svh"

module e1_loopback_alarm_control #(
	parameter int recovery_cycles = `E1_RECOVERY_CYCLES,
	parameter int mf_search_cycles = `E1_MF_SEARCH_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	// parallel control port
	input wire logic [7:0] port_addr,
	input wire logic [7:0] port_wdata,
	input wire logic port_wr,
	input wire logic port_rd,
	output logic [7:0] port_rdata,
	// receive timeslot stream from the framer
	input wire logic [7:0] rx_slot_data,
	input wire logic [4:0] rx_slot_index,
	input wire logic rx_slot_valid,
	// receive fault pins
	input wire e1_loop_pkg::rx_fault_t rx_fault_pins,
	// maintenance outputs
	output logic line_reset_pulse,
	output logic line_recovering,
	output logic elastic_store_reset_bit,
	// line side
	input wire logic transmit_line_clock_in,
	input wire logic receive_line_clock_in,
	input wire e1_loop_pkg::bipolar_t formatter_data,
	input wire e1_loop_pkg::bipolar_t rx_in,
	input wire e1_loop_pkg::bipolar_t line_recovered,
	input wire e1_loop_pkg::bipolar_t jitter_out,
	output e1_loop_pkg::bipolar_t jitter_in,
	output e1_loop_pkg::bipolar_t framer_rx,
	output e1_loop_pkg::bipolar_t tx_out,
	output logic recovered_clock_out,
	output logic remote_alarm_insert
);

	localparam int rec_w = $clog2(recovery_cycles + 1);
	localparam int mf_w = $clog2(mf_search_cycles + 1);

	////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] ctrl_one_reg;
	logic [7:0] ctrl_two_reg;
	logic [7:0] ctrl_three_reg;
	logic [7:0] ctrl_four_reg;
	logic [7:0] ctrl_five_reg;
	logic [7:0] mon_data_reg;
	logic [7:0] status_next;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_one_reg <= `E1_RESET_VALUE;
			ctrl_two_reg <= `E1_RESET_VALUE;
			ctrl_three_reg <= `E1_RESET_VALUE;
			ctrl_four_reg <= `E1_RESET_VALUE;
			ctrl_five_reg <= `E1_RESET_VALUE;
		end else if (port_wr) begin
			if (port_addr == `E1_ADDR_CTRL_ONE) begin
				ctrl_one_reg <= port_wdata;
			end else if (port_addr == `E1_ADDR_CTRL_TWO) begin
				ctrl_two_reg <= port_wdata;
			end else if (port_addr == `E1_ADDR_CTRL_THREE) begin
				ctrl_three_reg <= port_wdata;
			end else if (port_addr == `E1_ADDR_CTRL_FOUR) begin
				ctrl_four_reg <= port_wdata;
			end else if (port_addr == `E1_ADDR_CTRL_FIVE) begin
				// unassigned bits stored as written
				ctrl_five_reg <= port_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port_rdata <= 8'h00;
		end else if (port_rd) begin
			if (port_addr == `E1_ADDR_CTRL_ONE) begin
				port_rdata <= ctrl_one_reg;
			end else if (port_addr == `E1_ADDR_CTRL_TWO) begin
				port_rdata <= ctrl_two_reg;
			end else if (port_addr == `E1_ADDR_CTRL_THREE) begin
				port_rdata <= ctrl_three_reg;
			end else if (port_addr == `E1_ADDR_CTRL_FOUR) begin
				port_rdata <= ctrl_four_reg;
			end else if (port_addr == `E1_ADDR_CTRL_FIVE) begin
				port_rdata <= ctrl_five_reg;
			end else if (port_addr == `E1_ADDR_MON_DATA) begin
				port_rdata <= mon_data_reg;
			end else if (port_addr == `E1_ADDR_STATUS) begin
				port_rdata <= status_next;
			end else begin
				port_rdata <= 8'h00;
			end
		end
	end

	// level straight from the register bit
	assign elastic_store_reset_bit = ctrl_three_reg[`E1_BIT_ELASTIC_RESET]; // [R20]

	////////////////////////////////////////////////////////////////////
	// receive channel monitor

	logic [4:0] mon_select;
	assign mon_select = ctrl_five_reg[`E1_SEL_MSB:`E1_SEL_LSB];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mon_data_reg <= 8'h00;
		end else if (rx_slot_valid && rx_slot_index == mon_select) begin
			mon_data_reg <= rx_slot_data; // [R4]
		end
	end

	////////////////////////////////////////////////////////////////////
	// line interface reset and recovery

	logic line_reset_prev_reg;
	logic [rec_w-1:0] rec_count_reg;
	logic line_reset_bit;
	assign line_reset_bit = ctrl_five_reg[`E1_BIT_LINE_RESET];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			line_reset_prev_reg <= 1'b0;
			line_reset_pulse <= 1'b0;
		end else begin
			line_reset_prev_reg <= line_reset_bit;
			// only a fresh rising edge resets again
			line_reset_pulse <= line_reset_bit & ~line_reset_prev_reg; // [R1] [R21] [R2]
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rec_count_reg <= '0;
		end else if (line_reset_pulse) begin
			rec_count_reg <= rec_w'(recovery_cycles); // [R13]
		end else if (rec_count_reg != '0) begin
			rec_count_reg <= rec_count_reg - rec_w'(1);
		end
	end

	assign line_recovering = (rec_count_reg != '0);

	////////////////////////////////////////////////////////////////////
	// fault pin synchronisers

	logic [3:0] fault_s1_reg;
	logic [3:0] fault_s2_reg;
	logic [3:0] fault_s3_reg;
	logic [3:0] fault_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_fault_sync
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					fault_s1_reg[gi] <= 1'b0;
					fault_s2_reg[gi] <= 1'b0;
					fault_s3_reg[gi] <= 1'b0;
					fault_reg[gi] <= 1'b0;
				end else begin
					fault_s1_reg[gi] <= rx_fault_pins[gi];
					fault_s2_reg[gi] <= fault_s1_reg[gi];
					fault_s3_reg[gi] <= fault_s2_reg[gi];
					if (fault_s2_reg[gi] == fault_s3_reg[gi]) begin
						fault_reg[gi] <= fault_s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	e1_loop_pkg::rx_fault_t faults;
	assign faults = fault_reg;

	////////////////////////////////////////////////////////////////////
	// automatic alarms

	logic ais_auto;
	logic rai_auto;
	logic any_fault;
	logic [mf_w-1:0] mf_count_reg;
	logic const_rai_reg;
	logic send_ais;
	logic send_rai;

	assign ais_auto = ctrl_two_reg[`E1_BIT_AIS_AUTO];
	assign rai_auto = ctrl_two_reg[`E1_BIT_RAI_AUTO];
	assign any_fault = faults.frame_sync_lost | faults.ais_received | faults.carrier_lost; // [R16]

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mf_count_reg <= '0;
			const_rai_reg <= 1'b0;
		end else if (!rai_auto || faults.crc4_mf_found) begin
			mf_count_reg <= '0;
			const_rai_reg <= 1'b0;
		end else if (mf_count_reg == mf_w'(mf_search_cycles)) begin
			const_rai_reg <= 1'b1; // [R19]
		end else begin
			mf_count_reg <= mf_count_reg + mf_w'(1);
		end
	end

	// ais wins if both enables are set, an illegal setting
	assign send_ais = ais_auto & any_fault; // [R17] [R18]
	assign send_rai = ~ais_auto & rai_auto & (any_fault | const_rai_reg); // [R17] [R19]

	always_comb begin
		status_next = 8'h00;
		status_next[`E1_STAT_RECOVERING] = line_recovering;
		status_next[`E1_STAT_FAULT] = any_fault;
		status_next[`E1_STAT_CONST_RAI] = const_rai_reg;
		status_next[`E1_STAT_SEND_AIS] = send_ais;
		status_next[`E1_STAT_SEND_RAI] = send_rai;
	end

	////////////////////////////////////////////////////////////////////
	// crossing to the line clock

	e1_loop_pkg::link_ctrl_t ctrl_core_reg;
	e1_loop_pkg::link_ctrl_t ctrl_s1_reg;
	e1_loop_pkg::link_ctrl_t ctrl_link_reg;
	logic link_rst_s1_reg;
	logic link_rstn_reg;

	// registered so no decode glitch reaches the link flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_core_reg <= '0;
		end else begin
			ctrl_core_reg.framer_loop_mode <= ctrl_one_reg[`E1_BIT_FRAMER_LOOP];
			ctrl_core_reg.local_loop_mode <= ctrl_four_reg[`E1_BIT_LOCAL_LOOP];
			ctrl_core_reg.remote_loop_mode <= ctrl_four_reg[`E1_BIT_REMOTE_LOOP];
			ctrl_core_reg.send_ais <= send_ais;
			ctrl_core_reg.send_rai <= send_rai;
		end
	end

	// link reset asserts at once, releases on the link clock
	always_ff @(posedge transmit_line_clock_in or negedge rstn) begin
		if (!rstn) begin
			link_rst_s1_reg <= 1'b0;
			link_rstn_reg <= 1'b0;
		end else begin
			link_rst_s1_reg <= 1'b1;
			link_rstn_reg <= link_rst_s1_reg;
		end
	end

	// independent levels, each bit on its own two flops
	always_ff @(posedge transmit_line_clock_in or negedge link_rstn_reg) begin
		if (!link_rstn_reg) begin
			ctrl_s1_reg <= '0;
			ctrl_link_reg <= '0;
		end else begin
			ctrl_s1_reg <= ctrl_core_reg;
			ctrl_link_reg <= ctrl_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// line side data paths

	logic ais_phase_reg;
	e1_loop_pkg::bipolar_t tx_normal;
	e1_loop_pkg::bipolar_t tx_next;
	e1_loop_pkg::bipolar_t framer_next;

	always_comb begin
		// ais: all ones, marks alternating polarity
		if (ctrl_link_reg.send_ais) begin
			tx_normal.pos = ais_phase_reg; // [R17]
			tx_normal.neg = ~ais_phase_reg;
		end else begin
			tx_normal = formatter_data;
		end
		if (ctrl_link_reg.remote_loop_mode) begin
			tx_next = rx_in; // [R10] [R11]
		end else begin
			tx_next = tx_normal; // [R6] [R8]
		end
		if (ctrl_link_reg.framer_loop_mode) begin
			framer_next = tx_normal; // [R5] [R6]
		end else if (ctrl_link_reg.local_loop_mode) begin
			framer_next = jitter_out; // [R9]
		end else begin
			framer_next = rx_in; // [R11]
		end
	end

	always_ff @(posedge transmit_line_clock_in or negedge link_rstn_reg) begin
		if (!link_rstn_reg) begin
			ais_phase_reg <= 1'b0;
			tx_out <= '0;
			framer_rx <= '0;
			jitter_in <= '0;
			remote_alarm_insert <= 1'b0;
		end else begin
			ais_phase_reg <= ~ais_phase_reg;
			tx_out <= tx_next;
			framer_rx <= framer_next;
			// local loop feeds transmitted data into the attenuator
			jitter_in <= ctrl_link_reg.local_loop_mode ? tx_next : line_recovered; // [R8] [R9]
			remote_alarm_insert <= ctrl_link_reg.send_rai; // [R17]
		end
	end

	////////////////////////////////////////////////////////////////////
	// recovered clock switch

	// a plain mux glitches when its select moves between unrelated clocks;
	// each side drops its gate on its own falling edge before the other opens
	logic framer_sel;
	logic tx_gate_s1_reg;
	logic tx_gate_reg;
	logic rx_gate_s1_reg;
	logic rx_gate_reg;

	assign framer_sel = ctrl_one_reg[`E1_BIT_FRAMER_LOOP];

	always_ff @(negedge transmit_line_clock_in or negedge rstn) begin
		if (!rstn) begin
			tx_gate_s1_reg <= 1'b0;
			tx_gate_reg <= 1'b0;
		end else begin
			tx_gate_s1_reg <= framer_sel & ~rx_gate_reg;
			tx_gate_reg <= tx_gate_s1_reg;
		end
	end

	// receive side owns the output out of reset
	always_ff @(negedge receive_line_clock_in or negedge rstn) begin
		if (!rstn) begin
			rx_gate_s1_reg <= 1'b1;
			rx_gate_reg <= 1'b1;
		end else begin
			rx_gate_s1_reg <= ~framer_sel & ~tx_gate_reg;
			rx_gate_reg <= rx_gate_s1_reg;
		end
	end

	assign recovered_clock_out = (transmit_line_clock_in & tx_gate_reg) |
		(receive_line_clock_in & rx_gate_reg); // [R7]

endmodule

// ---- tb/e1_host_model.sv ----
// host processor model on the parallel control port
`timescale 1ns/10ps
module e1_host_model (
	input wire logic core_clk,
	input wire logic [7:0] port_rdata,
	output logic [7:0] port_addr,
	output logic [7:0] port_wdata,
	output logic port_wr,
	output logic port_rd
);
	initial begin
		port_addr = 8'h00;
		port_wdata = 8'h00;
		port_wr = 1'h0;
		port_rd = 1'h0;
	end
	// data scrambled once the write is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#2;
		port_addr = a;
		port_wdata = d;
		port_wr = 1'h1;
		@(posedge core_clk);
		#2;
		port_wr = 1'h0;
		port_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#2;
		port_addr = a;
		port_rd = 1'h1;
		@(posedge core_clk);
		#2;
		port_rd = 1'h0;
		d = port_rdata;
	endtask
endmodule

// ---- tb/e1_loopback_alarm_control_assertions.sv ----
// port assertions for the loopback and alarm control block
`timescale 1ns/10ps
module e1_loop_checker (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] port_addr,
	input wire logic [7:0] port_wdata,
	input wire logic port_wr,
	input wire logic line_reset_pulse,
	input wire logic line_recovering,
	input wire logic elastic_store_reset_bit,
	input wire logic transmit_line_clock_in,
	input wire logic receive_line_clock_in,
	input wire logic recovered_clock_out,
	input wire e1_loop_pkg::bipolar_t formatter_data,
	input wire e1_loop_pkg::bipolar_t rx_in,
	input wire e1_loop_pkg::bipolar_t jitter_out,
	input wire e1_loop_pkg::bipolar_t jitter_in,
	input wire e1_loop_pkg::bipolar_t framer_rx,
	input wire e1_loop_pkg::bipolar_t tx_out
);
	////////////////////////////////
	// shadow of framer, local, remote loop and line reset bits
	logic [2:0] mode_reg;
	logic lr_reg;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= 3'h0;
			lr_reg <= 1'h0;
		end else if (port_wr) begin
			if (port_addr == 8'h10)
				mode_reg[2] <= port_wdata[7];
			if (port_addr == 8'ha8)
				mode_reg[1:0] <= {port_wdata[6], port_wdata[7]};
			if (port_addr == 8'haa)
				lr_reg <= port_wdata[7];
		end
	end
	////////////////////////////////
	property p_line_reset;
		@(posedge core_clk) disable iff (!rstn) port_wr && port_addr == 8'haa && port_wdata[7] && !lr_reg
			|-> ##2 line_reset_pulse;
	endproperty
	a_line_reset: assert property (p_line_reset) else $error("no reset pulse");
	property p_pulse_once;
		@(posedge core_clk) disable iff (!rstn) line_reset_pulse |=> !line_reset_pulse;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("long reset pulse");
	property p_recover;
		@(posedge core_clk) disable iff (!rstn) line_reset_pulse |=> line_recovering [*8];
	endproperty
	a_recover: assert property (p_recover) else $error("recovery too short");
	property p_elastic;
		@(posedge core_clk) disable iff (!rstn) port_wr && port_addr == 8'h1b
			|=> elastic_store_reset_bit == $past(port_wdata[4]);
	endproperty
	a_elastic: assert property (p_elastic) else $error("elastic reset level");
	property p_clk_framer;
		@(posedge core_clk) disable iff (!rstn) mode_reg[2] [*8] |-> recovered_clock_out == transmit_line_clock_in;
	endproperty
	a_clk_framer: assert property (p_clk_framer) else $error("clock not replaced");
	property p_clk_normal;
		@(posedge core_clk) disable iff (!rstn) (!mode_reg[2]) [*8] |-> recovered_clock_out == receive_line_clock_in;
	endproperty
	a_clk_normal: assert property (p_clk_normal) else $error("receive clock not passed");
	property p_framer_loop;
		@(posedge transmit_line_clock_in) disable iff (!rstn) mode_reg[2] [*8] |=> framer_rx == $past(formatter_data);
	endproperty
	a_framer_loop: assert property (p_framer_loop) else $error("framer loop data");
	property p_local_loop;
		@(posedge transmit_line_clock_in) disable iff (!rstn) (mode_reg[1] && !mode_reg[2]) [*8]
			|=> jitter_in == $past(formatter_data) && framer_rx == $past(jitter_out);
	endproperty
	a_local_loop: assert property (p_local_loop) else $error("local loop data");
	property p_remote_loop;
		@(posedge transmit_line_clock_in) disable iff (!rstn) mode_reg[0] [*8] |=> tx_out == $past(rx_in);
	endproperty
	a_remote_loop: assert property (p_remote_loop) else $error("remote loop data");
endmodule
bind e1_loopback_alarm_control e1_loop_checker i_chk (.*);

// ---- tb/e1_loopback_alarm_control_bench.sv ----
// testbench for the loopback and alarm control block
`timescale 1ns/10ps
module e1_loopback_alarm_control_bench;
	logic core_clk = 1'h0;
	logic rstn = 1'h0;
	logic transmit_line_clock_in = 1'h0;
	logic receive_line_clock_in = 1'h0;
	logic [7:0] port_addr, port_wdata, port_rdata;
	logic port_wr, port_rd, line_reset_pulse, line_recovering, elastic_store_reset_bit;
	logic recovered_clock_out, remote_alarm_insert;
	logic [7:0] rx_slot_data = 8'h00;
	logic [4:0] rx_slot_index = 5'h00;
	logic rx_slot_valid = 1'h0;
	e1_loop_pkg::rx_fault_t rx_fault_pins = 4'h0;
	e1_loop_pkg::bipolar_t formatter_data = 2'h0, rx_in = 2'h2, jitter_out = 2'h3, line_recovered = 2'h0;
	e1_loop_pkg::bipolar_t jitter_in, framer_rx, tx_out;
	logic [7:0] cfg_addr [5] = '{8'h10, 8'h11, 8'h1b, 8'ha8, 8'haa};
	int n_fail = 0;
	int num_checks = 0;
	////////////////////////////////
	always #25 core_clk = ~core_clk;
	always #24 transmit_line_clock_in = ~transmit_line_clock_in;
	always #26 receive_line_clock_in = ~receive_line_clock_in;
	always @(posedge transmit_line_clock_in) begin
		#2;
		formatter_data <= formatter_data + 2'h1;
		line_recovered <= formatter_data + 2'h2;
		rx_in <= formatter_data + 2'h3;
		jitter_out <= formatter_data;
	end
	e1_loopback_alarm_control #(.recovery_cycles(20), .mf_search_cycles(30)) i_dut (.core_clk, .rstn,
		.port_addr, .port_wdata, .port_wr, .port_rd, .port_rdata, .rx_slot_data, .rx_slot_index,
		.rx_slot_valid, .rx_fault_pins, .line_reset_pulse, .line_recovering, .elastic_store_reset_bit,
		.transmit_line_clock_in, .receive_line_clock_in, .formatter_data, .rx_in, .line_recovered,
		.jitter_out, .jitter_in, .framer_rx, .tx_out, .recovered_clock_out, .remote_alarm_insert);
	e1_host_model i_host (.core_clk, .port_rdata, .port_addr, .port_wdata, .port_wr, .port_rd);
	////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_regs();
		logic [7:0] d;
		i_host.rd(8'ha8, d);
		chk(d, 8'h00);
		i_host.wr(8'h55, 8'hff);
		i_host.rd(8'h55, d);
		chk(d, 8'h00);
		i_host.wr(8'h1b, 8'h10);
		chk({7'h00, elastic_store_reset_bit}, 8'h01);
		i_host.wr(8'h1b, 8'h00);
		chk({7'h00, elastic_store_reset_bit}, 8'h00);
	endtask
	task automatic pulses(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		repeat (6) begin
			@(posedge core_clk);
			#1;
			n = n + {7'h00, line_reset_pulse};
		end
		chk(n, exp);
	endtask
	task automatic t_reset();
		i_host.wr(8'haa, 8'h80);
		pulses(8'h01);
		repeat (15) @(posedge core_clk);
		#1;
		chk({7'h00, line_recovering}, 8'h01);
		@(posedge core_clk);
		#1;
		chk({7'h00, line_recovering}, 8'h00);
		i_host.wr(8'haa, 8'h80);
		pulses(8'h00);
		i_host.wr(8'haa, 8'h00);
		i_host.wr(8'haa, 8'h80);
		pulses(8'h01);
	endtask
	task automatic slot(input logic [4:0] i, input logic [7:0] d);
		@(posedge core_clk);
		#2;
		rx_slot_index = i;
		rx_slot_data = d;
		rx_slot_valid = 1'h1;
		@(posedge core_clk);
		#2;
		rx_slot_valid = 1'h0;
	endtask
	task automatic t_mon(input logic [4:0] s, input logic [7:0] d);
		logic [7:0] r;
		i_host.wr(8'haa, {3'h0, s});
		slot(s, d);
		slot(s + 5'h01, ~d);
		i_host.rd(8'hac, r);
		chk(r, d);
	endtask
	task automatic t_line(input logic [7:0] a, input logic [7:0] d, input logic rl, input logic fl, input logic ll);
		i_host.wr(a, d);
		repeat (8) @(posedge transmit_line_clock_in);
		repeat (4) begin
			@(posedge transmit_line_clock_in);
			#1;
			chk({6'h00, tx_out}, {6'h00, rl ? rx_in : formatter_data});
			chk({6'h00, jitter_in}, {6'h00, ll ? formatter_data : line_recovered});
			if (fl)
				chk({6'h00, framer_rx}, {6'h00, formatter_data});
			else
				chk({6'h00, framer_rx}, {6'h00, ll ? jitter_out : rx_in});
		end
		#5;
		if (fl)
			chk({7'h00, recovered_clock_out}, {7'h00, transmit_line_clock_in});
		i_host.wr(a, 8'h00);
	endtask
	task automatic t_alarm();
		logic [7:0] r;
		logic [1:0] a;
		logic [1:0] b;
		logic [1:0] c;
		i_host.wr(8'h11, 8'h20);
		for (int i = 1; i < 4; i++) begin
			rx_fault_pins = 4'h1 << i;
			repeat (8) @(posedge core_clk);
			i_host.rd(8'had, r);
			chk(r, 8'h0a);
		end
		@(posedge transmit_line_clock_in);
		#1;
		a = tx_out;
		@(posedge transmit_line_clock_in);
		#1;
		b = tx_out;
		@(posedge transmit_line_clock_in);
		#1;
		c = tx_out;
		chk({4'h0, b, c}, {4'h0, ~a, a});
		i_host.wr(8'h11, 8'h10);
		repeat (8) @(posedge core_clk);
		i_host.rd(8'had, r);
		chk(r, 8'h12);
		repeat (40) @(posedge core_clk);
		i_host.rd(8'had, r);
		chk(r, 8'h16);
		chk({7'h00, remote_alarm_insert}, 8'h01);
		rx_fault_pins = 4'h0;
		repeat (8) @(posedge core_clk);
		i_host.rd(8'had, r);
		chk(r, 8'h14);
		chk({7'h00, remote_alarm_insert}, 8'h01);
		rx_fault_pins = 4'h1;
		repeat (10) @(posedge core_clk);
		i_host.rd(8'had, r);
		chk(r, 8'h00);
		chk({7'h00, remote_alarm_insert}, 8'h00);
		i_host.wr(8'h11, 8'h00);
	endtask
	////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk);
		#2;
		rstn = 1'h1;
		t_regs();
		foreach (cfg_addr[i]) i_host.wr(cfg_addr[i], 8'h00);
		t_reset();
		t_mon(5'h05, 8'ha5);
		t_mon(5'h1f, 8'h5a);
		t_line(8'h10, 8'h80, 1'h0, 1'h1, 1'h0);
		t_line(8'ha8, 8'h80, 1'h1, 1'h0, 1'h0);
		t_line(8'ha8, 8'h40, 1'h0, 1'h0, 1'h1);
		t_alarm();
		summarize();
	end
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule
